/* File: hdl/pdm_pkg.sv */
// pdm_pkg: register map, field layout, reset values, modes and wait table of the
// power-down mode controller.
// assumes a 32-bit axi4-lite register bus with 8-bit byte addresses.
package pdm_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_MSTOP_LOW = 8'h00;  // module_stop_control_low
  localparam logic [7:0] OFF_CLK_CTRL  = 8'h04;  // system_clock_control
  localparam logic [7:0] OFF_HARDWARE_STANDBY_PIN_CTRL = 8'h08;  // standby_control
  localparam logic [7:0] OFF_WAKE_EN   = 8'h0c;  // standby_wake_enable_reg
  localparam logic [7:0] OFF_INT_CTRL  = 8'h10;  // interrupt_control
  localparam logic [7:0] OFF_STATUS    = 8'h14;  // mode and active divider, read only

  // field positions
  localparam int DIV_LSB       = 0;  // clock_division_select, 3 bits
  localparam int HARDWARE_STANDBY_PIN_SEL_BIT  = 7;  // standby_select_bit
  localparam int HOLD_BIT      = 6;  // output_hold_enable
  localparam int STAB_LSB      = 0;  // stabilisation_time_select, 4 bits
  localparam int WAKE_BIT      = 0;  // standby_wake_enable
  localparam int NMI_EDGE_BIT  = 0;  // nmi_edge_select

  // module_stop_control_low bit owners
  localparam int ADC_STOP_BIT     = 6;
  localparam int SERIAL2_STOP_BIT = 3;
  localparam int SERIAL1_STOP_BIT = 2;
  localparam int SERIAL0_STOP_BIT = 1;
  localparam int TIMER8_STOP_BIT  = 0;

  // reset values
  localparam logic [7:0] MSTOP_RST = 8'hff;
  localparam logic [2:0] DIV_RST   = 3'h0;
  localparam logic [2:0] DIV_MAX   = 3'h5;  // 1/32, higher codes are ignored
  localparam logic [3:0] STAB_RST  = 4'hf;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // wait in divider-clock states per stabilisation code, code 15 first
  localparam logic [15:0][19:0] STAB_STATES = {
    20'h80000, 20'h40000, 20'h20000, 20'h10000,
    20'h08000, 20'h04000, 20'h01000, 20'h00800,
    20'h00400, 20'h00200, 20'h00040,
    20'h00040, 20'h00040, 20'h00040, 20'h00040, 20'h00040
  };

  typedef enum logic [2:0] {
    MODE_RUN, MODE_SLEEP, MODE_SWSTBY, MODE_WAKEWAIT, MODE_RST, MODE_HWSTBY
  } pdm_mode_e;

endpackage

/* File: hdl/pdm_ctrl.sv */
// pdm_ctrl: power-down mode controller with module stop, clock division, sleep,
// software standby with stabilisation wait, reset and hardware standby.
// assumes the cpu pulses sleep_req for one clock on a sleep instruction and that
// int_req and irq_req come already qualified from the interrupt controller.
//
// Overview of operation
// - module stop byte resets to all ones; bits 6,3..1,0 gate adc, serials, timer
// - writing one stops a module, writing zero releases it
// - stop changes take effect at bus cycle end; cpu keeps running
// - divider codes 1 to 5 select 1/2 to 1/32 at bus cycle end
// - divider code zero returns to full speed at bus cycle end
// - sleep instruction with standby select zero enters sleep; divider kept
// - sleep instruction with standby select one enters software standby; divider kept
// - reset pin low or watchdog reset enters reset and clears division
// - hardware standby pin low enters hardware standby from any mode
// - sleep halts cpu only; peripherals keep running
// - accepted interrupt ends sleep and starts interrupt exception
// - reset pin low in sleep gives reset; rising pin starts reset exception
// - standby stops cpu, peripherals and oscillator; serial and adc are reset
// - output hold enable chooses floating or held bus outputs in standby
// - standby wakes by nmi, reset or standby pin; irq lines need wake enable
// - wake restarts oscillator, waits programmed time, then starts interrupt exception
// - masked interrupts and transfer-controller sources never wake standby
// - reset low in standby feeds clocks at once; host holds until stable
// - codes 0 to 4 reserved; codes 5 to 15 select 64 to 524288 states
// - code 1011 selects 32768 states
// - nmi edge select zero means falling edge, one means rising edge
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module pdm_ctrl
  import pdm_pkg::*;
#(
  parameter int unsigned STAB_SHR = 0  // right shift of the wait, shortens it in simulation
) (
  // clock, reset, enable
  input  wire  logic        clock,
  input  wire  logic        sys_rst,
  input  wire  logic        ce,
  // axi4-lite slave
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // pins, asynchronous
  input  wire  logic        reset_pin_n,
  input  wire  logic        hardware_standby_pin_n,
  input  wire  logic        nmi_pin,
  // cpu and interrupt controller, same clock
  input  wire  logic        sleep_req,
  input  wire  logic        int_req,
  input  wire  logic [15:0] irq_req,
  input  wire  logic [15:0] irq_dtc_src,
  input  wire  logic        cpu_irq_mask,
  input  wire  logic        wdt_reset,
  // power control outputs
  output logic [7:0]        module_stop,
  output logic [2:0]        clk_div_sel,
  output logic              cpu_halt,
  output logic              periph_clk_stop,
  output logic              osc_stop,
  output logic              serial_adc_reset,
  output logic              bus_float,
  output logic              reset_state,
  output logic              hw_standby,
  output logic              int_exc_start,
  output logic              rst_exc_start
);

  typedef struct packed {
    pdm_mode_e   mode;
    logic [7:0]  mstop;
    logic [2:0]  div;
    logic        hardware_standby_pin_sel;
    logic        hold_out;
    logic [3:0]  stab_code;
    logic        wake_en;
    logic        nmi_rise;
    logic [19:0] cnt;
    logic        int_exc;
    logic        rst_exc;
    logic [2:0]  nmi_s;
    logic [1:0]  rpin_s;
    logic [1:0]  hpin_s;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pdm_state_s;

  pdm_state_s r;
  pdm_state_s n;

  logic wr_go;
  logic nmi_edge;
  logic wake_sleep;
  logic wake_hardware_standby_pin;
  logic pin_rst;
  logic pin_hw;

  // readies drop while frozen so nothing is taken that the state cannot record
  assign s_axi_awready = ce & ~r.aw_got;
  assign s_axi_wready  = ce & ~r.w_got;
  assign s_axi_arready = ce & ~r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;

  // wake qualification from synchronised pins
  assign wr_go      = r.aw_got & r.w_got & ~r.bvalid;
  assign pin_rst    = ~r.rpin_s[1];
  assign pin_hw     = ~r.hpin_s[1];
  assign nmi_edge   = r.nmi_rise ? (r.nmi_s[1] & ~r.nmi_s[2])
                                 : (~r.nmi_s[1] & r.nmi_s[2]);
  assign wake_sleep = int_req | nmi_edge;
  assign wake_hardware_standby_pin  = nmi_edge
                    | ((|(irq_req & ~irq_dtc_src)) & r.wake_en & ~cpu_irq_mask);

  // state decoded outputs
  assign module_stop      = r.mstop;
  assign clk_div_sel      = r.div;
  assign cpu_halt         = r.mode != MODE_RUN;
  assign periph_clk_stop  = r.mode inside {MODE_SWSTBY, MODE_WAKEWAIT, MODE_HWSTBY};
  assign osc_stop         = r.mode inside {MODE_SWSTBY, MODE_HWSTBY};
  assign serial_adc_reset = r.mode inside {MODE_SWSTBY, MODE_WAKEWAIT, MODE_RST,
                                           MODE_HWSTBY};
  assign bus_float        = ((r.mode inside {MODE_SWSTBY, MODE_WAKEWAIT}) & ~r.hold_out)
                          | (r.mode == MODE_HWSTBY);
  assign reset_state      = r.mode inside {MODE_RST, MODE_HWSTBY};
  assign hw_standby       = r.mode == MODE_HWSTBY;
  assign int_exc_start    = r.int_exc;
  assign rst_exc_start    = r.rst_exc;

  // next state: bus slave, register writes, mode sequence
  always_comb begin
    n         = r;
    n.int_exc = 1'b0;
    n.rst_exc = 1'b0;
    // two-flop synchronisers; the first stage feeds only the second
    n.nmi_s  = {r.nmi_s[1], r.nmi_s[0], nmi_pin};
    n.rpin_s = {r.rpin_s[0], reset_pin_n};
    n.hpin_s = {r.hpin_s[0], hardware_standby_pin_n};

    // address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got  = 1'b1;
      n.wdata  = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // write commits with its response: this is the end of the bus cycle
    if (wr_go) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      unique case (r.awaddr)
        OFF_MSTOP_LOW: if (r.wstrb0) n.mstop = r.wdata;
        OFF_CLK_CTRL: begin
          if (r.wstrb0 && r.wdata[DIV_LSB +: 3] <= DIV_MAX) begin
            n.div = r.wdata[DIV_LSB +: 3];
          end
        end
        OFF_HARDWARE_STANDBY_PIN_CTRL: begin
          if (r.wstrb0) begin
            n.hardware_standby_pin_sel  = r.wdata[HARDWARE_STANDBY_PIN_SEL_BIT];
            n.hold_out  = r.wdata[HOLD_BIT];
            n.stab_code = r.wdata[STAB_LSB +: 4];
          end
        end
        OFF_WAKE_EN:  if (r.wstrb0) n.wake_en = r.wdata[WAKE_BIT];
        OFF_INT_CTRL: if (r.wstrb0) n.nmi_rise = r.wdata[NMI_EDGE_BIT];
        OFF_STATUS:   n.bresp = RESP_OKAY;  // read only, write ignored
        default:      n.bresp = RESP_SLVERR;
      endcase
    end

    // reads answer one cycle after the address is taken
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_MSTOP_LOW: n.rdata = {24'h000000, r.mstop};
        OFF_CLK_CTRL:  n.rdata = {29'h00000000, r.div};
        OFF_HARDWARE_STANDBY_PIN_CTRL: n.rdata = {24'h000000, r.hardware_standby_pin_sel, r.hold_out, 2'h0, r.stab_code};
        OFF_WAKE_EN:   n.rdata = {31'h00000000, r.wake_en};
        OFF_INT_CTRL:  n.rdata = {31'h00000000, r.nmi_rise};
        OFF_STATUS:    n.rdata = {26'h0000000, r.mode, r.div};
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end

    // mode sequence
    unique case (r.mode)
      MODE_RUN: begin
        if (sleep_req) begin
          n.mode = r.hardware_standby_pin_sel ? MODE_SWSTBY : MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (wake_sleep) begin
          n.mode    = MODE_RUN;
          n.int_exc = 1'b1;
        end
      end
      MODE_SWSTBY: begin
        if (wake_hardware_standby_pin) begin
          n.mode = MODE_WAKEWAIT;
          n.cnt  = STAB_STATES[r.stab_code] >> STAB_SHR;
        end
      end
      MODE_WAKEWAIT: begin
        if (r.cnt == 20'h00000) begin
          n.mode    = MODE_RUN;
          n.int_exc = 1'b1;
        end else begin
          n.cnt = r.cnt - 20'h00001;
        end
      end
      MODE_RST: begin
        n.mode    = MODE_RUN;
        n.rst_exc = 1'b1;
      end
      MODE_HWSTBY: n.mode = MODE_RST;  // standby pin released: reset state follows whether or not reset is held
      // codes 6 and 7 are unused; an upset state falls back to reset, not a hang
      default:     n.mode = MODE_RST;
    endcase

    // pins override everything; reset state returns all registers to defaults
    if (pin_hw || pin_rst || wdt_reset) begin
      n.mode      = pin_hw ? MODE_HWSTBY : MODE_RST;
      n.mstop     = MSTOP_RST;
      n.div       = DIV_RST;
      n.hardware_standby_pin_sel  = 1'b0;
      n.hold_out  = 1'b0;
      n.stab_code = STAB_RST;
      n.wake_en   = 1'b0;
      n.nmi_rise  = 1'b0;
      n.cnt       = 20'h00000;
      n.int_exc   = 1'b0;
      n.rst_exc   = 1'b0;
    end
  end

  // state register; reset acts regardless of the clock enable
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r           <= '0;
      r.mode      <= MODE_RST;
      r.mstop     <= MSTOP_RST;
      r.div       <= DIV_RST;
      r.stab_code <= STAB_RST;
      r.hpin_s    <= 2'h3;
    end else if (ce) begin
      r <= n;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic in_run;
  logic pins_ok;
  assign in_run  = r.mode == MODE_RUN;
  assign pins_ok = ~pin_hw & ~pin_rst & ~wdt_reset;

  mstop_reset_a: assert property ($fell(sys_rst) |-> r.mstop == MSTOP_RST)
    else $error("module stop byte not all ones after reset");

  mstop_write_a: assert property (ce && wr_go && r.awaddr == OFF_MSTOP_LOW && r.wstrb0
                                  && pins_ok |=> module_stop == $past(r.wdata))
    else $error("module stop write not applied");

  stop_at_resp_a: assert property (!$stable(module_stop) && !$past(pins_ok)
                                   || $stable(module_stop) || $rose(s_axi_bvalid))
    else $error("module stop changed outside a write response");

  div_write_a: assert property (ce && wr_go && r.awaddr == OFF_CLK_CTRL && r.wstrb0
                                && r.wdata[2:0] <= DIV_MAX && pins_ok
                                |=> clk_div_sel == $past(r.wdata[2:0]))
    else $error("divider write not applied at bus cycle end");

  div_zero_a: assert property (ce && wr_go && r.awaddr == OFF_CLK_CTRL && r.wstrb0
                               && r.wdata[2:0] == 3'h0 |=> clk_div_sel == 3'h0)
    else $error("divider not back to full speed");

  sleep_entry_a: assert property (ce && in_run && sleep_req && pins_ok
                                  |=> r.mode == ($past(r.hardware_standby_pin_sel) ? MODE_SWSTBY
                                                                   : MODE_SLEEP))
    else $error("sleep request chose the wrong mode");

  div_kept_a: assert property (r.mode == MODE_SLEEP && pins_ok && !wr_go
                               |=> $stable(clk_div_sel))
    else $error("divider lost during sleep");

  reset_div_a: assert property (r.mode == MODE_RST |-> clk_div_sel == DIV_RST)
    else $error("reset state kept clock division");

  hw_entry_a: assert property (ce && pin_hw |=> r.mode == MODE_HWSTBY && hw_standby)
    else $error("standby pin did not enter hardware standby");

  sleep_wake_a: assert property (ce && r.mode == MODE_SLEEP && wake_sleep && pins_ok
                                 |=> in_run && int_exc_start)
    else $error("interrupt did not end sleep");

  hardware_standby_pin_hold_a: assert property (ce && r.mode == MODE_SWSTBY && !wake_hardware_standby_pin && pins_ok
                                |=> r.mode == MODE_SWSTBY && osc_stop)
    else $error("standby left without a wake source");

  wait_count_a: assert property (ce && r.mode == MODE_WAKEWAIT && r.cnt != 20'h00000
                                 && pins_ok |=> r.cnt == $past(r.cnt) - 20'h00001
                                 && !osc_stop && periph_clk_stop)
    else $error("stabilisation wait did not count down");

  float_sel_a: assert property (r.mode == MODE_SWSTBY |-> bus_float == !r.hold_out)
    else $error("bus float does not follow output hold enable");

  sleep_cover_c: cover property (r.mode == MODE_SLEEP ##1 in_run && int_exc_start);
  hardware_standby_pin_cover_c:  cover property (r.mode == MODE_WAKEWAIT ##1 in_run && int_exc_start);
  hw_cover_c:    cover property (hw_standby ##1 r.mode == MODE_RST);
  rst_cover_c:   cover property (rst_exc_start);

endmodule

/* File: sim/pdm_cpu_model.sv */
// pdm_cpu_model: cpu and interrupt controller as seen by the power-down controller.
// assumes the bench calls its tasks just after a rising edge of clock.
`timescale 1ns/10ps

module pdm_cpu_model (
  // clock
  input  wire logic   clock,
  // requests toward the controller
  output logic        sleep_req,
  output logic        int_req,
  output logic [15:0] irq_req,
  output logic [15:0] irq_dtc_src,
  output logic        cpu_irq_mask
);
  // quiet until the bench asks for something
  initial begin
    sleep_req    = 1'b0;
    int_req      = 1'b0;
    irq_req      = 16'h0000;
    irq_dtc_src  = 16'h0000;
    cpu_irq_mask = 1'b0;
  end

  // a sleep instruction is a strobe of exactly one clock, never two in a row
  task automatic sleep_pulse();
    sleep_req <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b0;
  endtask

  // interrupt lines are levels; no higher-priority source is ever left pending
  task automatic set_int(input logic il, input logic [15:0] irq, input logic [15:0] transfer_controller,
                         input logic msk);
    int_req      <= il;
    irq_req      <= irq;
    irq_dtc_src  <= transfer_controller;
    cpu_irq_mask <= msk;
  endtask
endmodule

/* File: sim/power_down_mode_controller_tb.sv */
// power_down_mode_controller_tb: registers, clock division, sleep, standby, resets.
// assumes pdm_ctrl and pdm_cpu_model; waits shortened through STAB_SHR.
`timescale 1ns/10ps

module power_down_mode_controller_tb;
  import pdm_pkg::*;
  localparam int SHR = 3;  // 64 states -> 8 cycles, 32768 -> 4096

  // stimulus, given a value at time zero
  logic        clock = 1'b0, sys_rst = 1'b1, wdt_reset = 1'b0, nmi_pin = 1'b0, ce = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        reset_pin_n = 1'b1, hardware_standby_pin_n = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, module_stop;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0, code;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  clk_div_sel;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cpu_halt, periph_clk_stop, osc_stop, serial_adc_reset, bus_float;
  logic        reset_state, hw_standby, int_exc_start, rst_exc_start;
  logic        sleep_req, int_req, cpu_irq_mask;
  logic [15:0] irq_req, irq_dtc_src;
  int          errors = 0, comparisons = 0, cycles = 0, n;

  pdm_ctrl #(.STAB_SHR(SHR)) i_pdm_ctrl (
    .clock, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_n,
    .hardware_standby_pin_n, .nmi_pin, .sleep_req, .int_req, .irq_req, .irq_dtc_src,
    .cpu_irq_mask, .wdt_reset, .module_stop, .clk_div_sel, .cpu_halt, .periph_clk_stop,
    .osc_stop, .serial_adc_reset, .bus_float, .reset_state, .hw_standby,
    .int_exc_start, .rst_exc_start
  );

  pdm_cpu_model i_pdm_cpu_model (
    .clock, .sleep_req, .int_req, .irq_req, .irq_dtc_src, .cpu_irq_mask
  );

  // 200 MHz
  always #2.5 clock = ~clock;

  // the longest wait is about 4100 cycles, the whole run well under 10000
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  // all checks read values at a rising edge, before that edge's updates land
  function automatic logic seen(input int s);
    case (s)
      0: return reset_state === 1'b1;
      1: return rst_exc_start === 1'b1;
      2: return int_exc_start === 1'b1;
      default: return osc_stop === 1'b0;
    endcase
  endfunction

  // n counts the edges waited; a pulse is never missed since every edge is looked at
  task automatic wait_on(input int s);
    n = 0;
    while (!seen(s) && n < 9000) begin
      @(posedge clock);
      n++;
    end
    chk("wait", 1'b1, seen(s));
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask

  // in standby, nothing may wake it for a while
  task automatic blocked();
    tick(12);
    chk("osc_stop", 1'b1, osc_stop);
  endtask

  initial begin
    tick(4);
    sys_rst <= 1'b0;
    wait_on(1);
    axi_rd(OFF_MSTOP_LOW, 32'h000000ff, RESP_OKAY);
    axi_rd(OFF_HARDWARE_STANDBY_PIN_CTRL, 32'h0000000f, RESP_OKAY);
    axi_rd(8'h18, 32'h00000000, RESP_SLVERR);
    axi_wr(8'h18, 32'h00000001, RESP_SLVERR);
    // status is read only: a write answers okay and changes nothing
    axi_wr(OFF_STATUS, 32'h0000003f, RESP_OKAY);
    axi_rd(OFF_STATUS, 32'h00000000, RESP_OKAY);
    axi_wr(OFF_MSTOP_LOW, 32'h0000005a, RESP_OKAY);
    chk("module_stop", 8'h5a, module_stop);
    axi_rd(OFF_MSTOP_LOW, 32'h0000005a, RESP_OKAY);
    $display("test registers done");
    // code 6 is not a divider and leaves 1/32 in place
    for (int i = 1; i <= 6; i++) begin
      axi_wr(OFF_CLK_CTRL, i, RESP_OKAY);
      chk("clk_div_sel", (i > 5) ? 5 : i, clk_div_sel);
      axi_rd(OFF_STATUS, (i > 5) ? 5 : i, RESP_OKAY);
    end
    axi_wr(OFF_CLK_CTRL, 32'h00000000, RESP_OKAY);
    chk("clk_div_sel", 3'h0, clk_div_sel);
    $display("test division done");
    axi_wr(OFF_CLK_CTRL, 32'h00000003, RESP_OKAY);
    axi_wr(OFF_HARDWARE_STANDBY_PIN_CTRL, 32'h0000000f, RESP_OKAY);
    i_pdm_cpu_model.sleep_pulse();
    tick(1);
    chk("cpu_halt", 1'b1, cpu_halt);
    chk("periph_clk_stop", 1'b0, periph_clk_stop);
    chk("osc_stop", 1'b0, osc_stop);
    chk("serial_adc_reset", 1'b0, serial_adc_reset);
    chk("bus_float", 1'b0, bus_float);
    chk("reset_state", 1'b0, reset_state);
    i_pdm_cpu_model.set_int(1'b1, 16'h0000, 16'h0000, 1'b0);
    wait_on(2);
    i_pdm_cpu_model.set_int(1'b0, 16'h0000, 16'h0000, 1'b0);
    chk("cpu_halt", 1'b0, cpu_halt);
    chk("clk_div_sel", 3'h3, clk_div_sel);
    $display("test sleep done");
    // pass 0 wakes by irq line 0, pass 1 by a rising nmi, pass 2 by a falling nmi
    for (int r = 0; r < 3; r++) begin
      code = (r == 1) ? 4'hb : 4'h5;
      axi_wr(OFF_INT_CTRL, r == 1, RESP_OKAY);
      axi_wr(OFF_HARDWARE_STANDBY_PIN_CTRL, {24'h000000, 1'b1, r[0], 2'h0, code}, RESP_OKAY);
      axi_wr(OFF_CLK_CTRL, 32'h00000002, RESP_OKAY);
      axi_wr(OFF_WAKE_EN, r != 0, RESP_OKAY);
      i_pdm_cpu_model.sleep_pulse();
      tick(1);
      chk("osc_stop", 1'b1, osc_stop);
      chk("periph_clk_stop", 1'b1, periph_clk_stop);
      chk("serial_adc_reset", 1'b1, serial_adc_reset);
      chk("bus_float", !r[0], bus_float);
      if (r == 0) begin
        i_pdm_cpu_model.set_int(1'b0, 16'h0001, 16'h0000, 1'b0);
        blocked();
        i_pdm_cpu_model.set_int(1'b0, 16'h0001, 16'h0001, 1'b0);
        axi_wr(OFF_WAKE_EN, 32'h00000001, RESP_OKAY);
        blocked();
        i_pdm_cpu_model.set_int(1'b0, 16'h0001, 16'h0000, 1'b1);
        blocked();
        i_pdm_cpu_model.set_int(1'b0, 16'h0001, 16'h0000, 1'b0);
      end else begin
        nmi_pin <= r[0];
      end
      wait_on(3);
      // frozen edges are no divider states; if the count ran on, n would come out 3 short of wake_cycles
      if (r == 2) begin
        ce <= 1'b0;
        tick(3);
        ce <= 1'b1;
      end
      wait_on(2);
      chk("wake_cycles", (((r == 1) ? 32768 : 64) >> SHR) + 1, n);
      i_pdm_cpu_model.set_int(1'b0, 16'h0000, 16'h0000, 1'b0);
      chk("clk_div_sel", 3'h2, clk_div_sel);
      $display("test standby %0d done", r);
    end
    // reset pin from sleep and standby, watchdog from sleep, standby pin from standby
    for (int s = 0; s < 4; s++) begin
      axi_wr(OFF_CLK_CTRL, 32'h00000004, RESP_OKAY);
      axi_wr(OFF_HARDWARE_STANDBY_PIN_CTRL, {24'h000000, s[0], 7'h0f}, RESP_OKAY);
      i_pdm_cpu_model.sleep_pulse();
      tick(1);
      case (s)
        0, 1: reset_pin_n <= 1'b0;
        2: wdt_reset <= 1'b1;
        default: hardware_standby_pin_n <= 1'b0;
      endcase
      wait_on(0);
      tick(2);
      chk("clk_div_sel", 3'h0, clk_div_sel);
      chk("hw_standby", s == 3, hw_standby);
      chk("osc_stop", s == 3, osc_stop);
      {reset_pin_n, wdt_reset, hardware_standby_pin_n} <= 3'b101;
      wait_on(1);
      chk("cpu_halt", 1'b0, cpu_halt);
      chk("module_stop", 8'hff, module_stop);
      $display("test reset source %0d done", s);
    end
    complete_run();
  end
endmodule
